// File: pif_pkg.sv
// Package: register map, field layout and reset values of the peripheral interrupt flags
package pif_pkg;

    // ========================================================================
    // Register bus geometry
    // ========================================================================
    localparam int PIF_ADDR_W = 4;
    localparam int PIF_DATA_W = 8;

    typedef logic [PIF_ADDR_W-1:0] pif_addr_t;
    typedef logic [PIF_DATA_W-1:0] pif_byte_t;

    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam pif_addr_t PIF_OFS_CORE_CTRL = 4'h0; // core_irq_control
    localparam pif_addr_t PIF_OFS_ENABLE_1  = 4'h1; // periph_irq_enable_1
    localparam pif_addr_t PIF_OFS_ENABLE_2  = 4'h2; // periph_irq_enable_2
    localparam pif_addr_t PIF_OFS_ENABLE_3  = 4'h3; // periph_irq_enable_3
    localparam pif_addr_t PIF_OFS_REQUEST_1 = 4'h4; // periph_irq_request_1
    localparam pif_addr_t PIF_OFS_REQUEST_2 = 4'h5; // periph_irq_request_2
    localparam pif_addr_t PIF_OFS_REQUEST_3 = 4'h6; // periph_irq_request_3
    localparam pif_addr_t PIF_OFS_EVT_STAT  = 4'h7; // Sticky event status, write one to clear
    localparam pif_addr_t PIF_OFS_EVT_MASK  = 4'h8; // Event mask, same layout
    localparam pif_addr_t PIF_OFS_SUMMARY   = 4'h9; // Read-only live state

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int PIF_BIT_GLOBAL_GATE = 7;     // global_irq_gate
    localparam int PIF_BIT_PERIPH_GATE = 6;     // peripheral_irq_gate
    localparam int PIF_BIT_SERIAL_RX   = 5;     // serial_rx_pending in request 1
    localparam int PIF_BIT_SERIAL_TX   = 4;     // serial_tx_pending in request 1
    localparam int PIF_BIT_OUTGEN      = 5;     // outgen_shutdown in register set 3
    localparam int PIF_BIT_ZERO_CROSS  = 4;     // zero_cross in register set 3
    localparam int PIF_EVT_FLAG_SET    = 0;     // A source set a request flag
    localparam int PIF_EVT_RO_WRITE    = 1;     // Software tried to change a read-only flag
    localparam int PIF_EVT_REQ_RISE    = 2;     // Combined peripheral request rose
    localparam int PIF_SUM_PERIPH_REQ  = 0;     // Summary: combined request
    localparam int PIF_SUM_ANY_FLAG    = 1;     // Summary: any flag pending

    // ========================================================================
    // Implemented, writable and source-owned bit masks
    // ========================================================================
    localparam pif_byte_t PIF_CTRL_MASK   = 8'hC0;
    localparam pif_byte_t PIF_SET1_MASK   = 8'hFF;
    localparam pif_byte_t PIF_SET2_MASK   = 8'hEF;
    localparam pif_byte_t PIF_SET3_MASK   = 8'h37;
    localparam pif_byte_t PIF_REQ1_WRMASK = 8'hCF;
    localparam pif_byte_t PIF_REQ1_LEVEL  = 8'h30;
    localparam pif_byte_t PIF_NO_LEVEL    = 8'h00;
    localparam pif_byte_t PIF_EVT_MASK    = 8'h07;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam pif_byte_t PIF_RST_VALUE   = 8'h00;
    localparam pif_byte_t PIF_READ_ZERO   = 8'h00;

endpackage

// File: pif_flag_reg.sv
// One eight-bit request register: source set, software write, source-owned levels
`timescale 1ns/1ps

module pif_flag_reg
    import pif_pkg::*;
#(
    parameter pif_byte_t IMPL_MASK = 8'hFF,
    parameter pif_byte_t WR_MASK   = 8'hFF,
    parameter pif_byte_t LVL_MASK  = 8'h00
)
(
    input  wire logic      clk_sys_i,
    input  wire logic      nrst_i,
    input  wire pif_byte_t set_i,
    input  wire pif_byte_t level_i,
    input  wire logic      wr_i,
    input  wire pif_byte_t wdata_i,
    output pif_byte_t      flags_o
);

    pif_byte_t                 flags_r;
    wire [PIF_DATA_W-1:0]      flags_nxt;

    // ========================================================================
    // Flag next state
    // ========================================================================
    // Per-bit priority: source level, then source set, then software write.
    // Set beats a same-cycle clear so an event is never lost.
    genvar b;
    generate
        for (b = 0; b < PIF_DATA_W; b++)
        begin : g_bit
            if (!IMPL_MASK[b])
            begin : g_unused
                assign flags_nxt[b] = 1'b0;                         // [R4]
            end
            else if (LVL_MASK[b])
            begin : g_level
                assign flags_nxt[b] = level_i[b];                   // [R11] [R14]
            end
            else
            begin : g_sticky
                assign flags_nxt[b] = set_i[b]                      // [R2] [R6]
                                      | ((wr_i && WR_MASK[b]) ? wdata_i[b] : flags_r[b]); // [R14]
            end
        end
    endgenerate

    // One register for the whole byte keeps every bit on a single driver
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            flags_r <= PIF_RST_VALUE;                               // [R5]
        else
            flags_r <= flags_nxt;
    end

    assign flags_o = flags_r;

endmodule

// File: pif_top.sv
// Peripheral interrupt flags: enables, request flags, gating toward the core
//
// Operation
// R1 - Peripheral gate clear blocks every peripheral interrupt
// R2 - Flags set on event regardless of enables
// R3 - Software clears flags before enabling sources
// R4 - Unused bits ignore writes, read zero
// R5 - All enables and flags reset to zero
// R6 - Flag one means pending, zero not
// R7 - Enable one allows source, zero blocks
// R8 - Enable set three bit layout
// R9 - Request set three bit layout
// R10 - Request set one bit layout
// R11 - Serial receive, transmit flags read-only
// R12 - Request set two bit layout
// R13 - Combined request: flag, enable, peripheral gate
// R14 - Writes store flag; read-only cleared by source
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module pif_top
    import pif_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire logic      nrst_i,
    input  wire pif_addr_t addr_i,
    input  wire pif_byte_t wdata_i,
    input  wire logic      wr_i,
    input  wire logic      rd_i,
    output pif_byte_t      rdata_o,
    input  wire pif_byte_t req1_evt_i,
    input  wire pif_byte_t req2_evt_i,
    input  wire pif_byte_t req3_evt_i,
    input  wire logic      serial_rx_pending_i,
    input  wire logic      serial_tx_pending_i,
    output logic           periph_irq_o,
    output logic           global_irq_gate_o,
    output logic           peripheral_irq_gate_o,
    output logic           irq_o
);

    // ========================================================================
    // Declarations
    // ========================================================================
    pif_byte_t ctrl_r;
    pif_byte_t enable_r [3];
    pif_byte_t request [3];
    pif_byte_t evt_r [3];
    pif_byte_t evt_stat_r;
    pif_byte_t evt_mask_r;
    pif_byte_t evt_stat_nxt;
    pif_byte_t rdata_r;
    pif_byte_t rdata_nxt;
    pif_byte_t level_req1;
    logic      periph_req_r;
    logic      periph_req_nxt;
    logic      irq_r;
    logic      any_match;
    logic      any_flag;
    logic      any_set;
    logic      ro_write;

    // Register select, used by every write path and by the assertions; the read mux decodes addr_i itself
    function automatic logic hit(input pif_addr_t a, input pif_addr_t ofs, input logic stb);
        hit = stb && (a == ofs);
    endfunction

    // Implemented-bit mask of each of the three register sets
    function automatic pif_byte_t set_mask(input int idx);
        case (idx)
            0:       set_mask = PIF_SET1_MASK;
            1:       set_mask = PIF_SET2_MASK;
            default: set_mask = PIF_SET3_MASK;
        endcase
    endfunction

    // ========================================================================
    // Core control register
    // ========================================================================
    // Only the two gate bits live here; the other bits belong elsewhere and read zero
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            ctrl_r <= PIF_RST_VALUE;                                // [R5]
        else if (hit(addr_i, PIF_OFS_CORE_CTRL, wr_i))
            ctrl_r <= wdata_i & PIF_CTRL_MASK;                      // [R4]
    end

    // ========================================================================
    // Enable registers
    // ========================================================================
    // Writes are masked so unused positions never hold a one
    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_enable
            always_ff @(posedge clk_sys_i)
            begin
                if (!nrst_i)
                    enable_r[i] <= PIF_RST_VALUE;                   // [R5]
                else if (hit(addr_i, PIF_OFS_ENABLE_1 + pif_addr_t'(i), wr_i))
                    enable_r[i] <= wdata_i & set_mask(i);           // [R4] [R8]
            end
        end
    endgenerate

    // ========================================================================
    // Request registers
    // ========================================================================
    // Serial receive/transmit flags mirror the serial unit's own state
    assign level_req1 = {2'b00, serial_rx_pending_i, serial_tx_pending_i, 4'h0}; // [R11]
    assign evt_r[0]   = req1_evt_i;
    assign evt_r[1]   = req2_evt_i;
    assign evt_r[2]   = req3_evt_i;

    pif_flag_reg #(
        .IMPL_MASK (PIF_SET1_MASK),
        .WR_MASK   (PIF_REQ1_WRMASK),
        .LVL_MASK  (PIF_REQ1_LEVEL)
    ) u_req1 (                                                      // [R10] [R11]
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (req1_evt_i),
        .level_i   (level_req1),
        .wr_i      (hit(addr_i, PIF_OFS_REQUEST_1, wr_i)),
        .wdata_i   (wdata_i),
        .flags_o   (request[0])
    );

    pif_flag_reg #(
        .IMPL_MASK (PIF_SET2_MASK),
        .WR_MASK   (PIF_SET2_MASK),
        .LVL_MASK  (PIF_NO_LEVEL)
    ) u_req2 (                                                      // [R12]
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (req2_evt_i),
        .level_i   (PIF_READ_ZERO),
        .wr_i      (hit(addr_i, PIF_OFS_REQUEST_2, wr_i)),
        .wdata_i   (wdata_i),
        .flags_o   (request[1])
    );

    pif_flag_reg #(
        .IMPL_MASK (PIF_SET3_MASK),
        .WR_MASK   (PIF_SET3_MASK),
        .LVL_MASK  (PIF_NO_LEVEL)
    ) u_req3 (                                                      // [R9]
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (req3_evt_i),
        .level_i   (PIF_READ_ZERO),
        .wr_i      (hit(addr_i, PIF_OFS_REQUEST_3, wr_i)),
        .wdata_i   (wdata_i),
        .flags_o   (request[2])
    );

    // ========================================================================
    // Combined request toward the core
    // ========================================================================
    // Registered, so the core sees it one cycle after the flag lands
    always_comb
    begin
        any_match = 1'b0;
        any_flag  = 1'b0;
        any_set   = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            any_match = any_match | (|(request[k] & enable_r[k]));  // [R7] [R13]
            any_flag  = any_flag | (|request[k]);
            any_set   = any_set | (|(evt_r[k] & set_mask(k)));
        end
        periph_req_nxt = any_match && ctrl_r[PIF_BIT_PERIPH_GATE];  // [R1] [R13]
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            periph_req_r <= 1'b0;
        else
            periph_req_r <= periph_req_nxt;                         // [R13]
    end

    // ========================================================================
    // Event status, mask and interrupt line
    // ========================================================================
    // A write that tries to flip a source-owned flag is refused and reported
    assign ro_write = hit(addr_i, PIF_OFS_REQUEST_1, wr_i)
                      && (((wdata_i ^ request[0]) & PIF_REQ1_LEVEL) != PIF_READ_ZERO); // [R11]

    // Set wins over a same-cycle write-one-to-clear
    always_comb
    begin
        evt_stat_nxt = evt_stat_r;
        if (hit(addr_i, PIF_OFS_EVT_STAT, wr_i))
            evt_stat_nxt = evt_stat_nxt & ~wdata_i;
        evt_stat_nxt[PIF_EVT_FLAG_SET] = evt_stat_nxt[PIF_EVT_FLAG_SET] | any_set;
        evt_stat_nxt[PIF_EVT_RO_WRITE] = evt_stat_nxt[PIF_EVT_RO_WRITE] | ro_write;
        evt_stat_nxt[PIF_EVT_REQ_RISE] = evt_stat_nxt[PIF_EVT_REQ_RISE]
                                         | (periph_req_nxt & ~periph_req_r);
        evt_stat_nxt = evt_stat_nxt & PIF_EVT_MASK;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            evt_stat_r <= PIF_RST_VALUE;
        else
            evt_stat_r <= evt_stat_nxt;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            evt_mask_r <= PIF_RST_VALUE;
        else if (hit(addr_i, PIF_OFS_EVT_MASK, wr_i))
            evt_mask_r <= wdata_i & PIF_EVT_MASK;
    end

    // Level output, registered on the same edge as the status it reflects
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            irq_r <= 1'b0;
        else
            irq_r <= |(evt_stat_nxt & evt_mask_r);
    end

    // ========================================================================
    // Read path
    // ========================================================================
    // Data stand in the cycle after the strobe only; unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = PIF_READ_ZERO;
        if (rd_i)
        begin
            case (addr_i)
                PIF_OFS_CORE_CTRL: rdata_nxt = ctrl_r;
                PIF_OFS_ENABLE_1:  rdata_nxt = enable_r[0];
                PIF_OFS_ENABLE_2:  rdata_nxt = enable_r[1];
                PIF_OFS_ENABLE_3:  rdata_nxt = enable_r[2];
                PIF_OFS_REQUEST_1: rdata_nxt = request[0];          // [R6]
                PIF_OFS_REQUEST_2: rdata_nxt = request[1];          // [R6]
                PIF_OFS_REQUEST_3: rdata_nxt = request[2];          // [R6]
                PIF_OFS_EVT_STAT:  rdata_nxt = evt_stat_r;
                PIF_OFS_EVT_MASK:  rdata_nxt = evt_mask_r;
                PIF_OFS_SUMMARY:   rdata_nxt = {6'h00, any_flag, periph_req_r};
                default:           rdata_nxt = PIF_READ_ZERO;       // [R4]
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            rdata_r <= PIF_RST_VALUE;
        else
            rdata_r <= rdata_nxt;
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign rdata_o               = rdata_r;
    assign periph_irq_o          = periph_req_r;
    assign global_irq_gate_o     = ctrl_r[PIF_BIT_GLOBAL_GATE];
    assign peripheral_irq_gate_o = ctrl_r[PIF_BIT_PERIPH_GATE];
    assign irq_o                 = irq_r;

    // ========================================================================
    // Assertions
    // ========================================================================
    property p_gate_blocks;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !ctrl_r[PIF_BIT_PERIPH_GATE] |=> !periph_irq_o;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) // [R1]
        else $error("Peripheral request raised with the peripheral gate clear");

    property p_set_on_event;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (req2_evt_i[7] && !ctrl_r[PIF_BIT_GLOBAL_GATE] && !enable_r[1][7])
        |=> request[1][7] ##1 (request[1][7] || $past(hit(addr_i, PIF_OFS_REQUEST_2, wr_i)));
    endproperty
    a_set_on_event: assert property (p_set_on_event) // [R2]
        else $error("Request flag not set by its source event");

    property p_unused_zero;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        hit(addr_i, PIF_OFS_ENABLE_3, wr_i) |=> (enable_r[2] & ~PIF_SET3_MASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // [R4]
        else $error("Unused enable bit holds a one");

    property p_reset_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> (enable_r[0] == 8'h00 && enable_r[2] == 8'h00
                           && request[1] == 8'h00 && request[2] == 8'h00 && !periph_irq_o);
    endproperty
    a_reset_clear: assert property (p_reset_clear) // [R5]
        else $error("Enable or request not zero after reset");

    property p_read_flags;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        hit(addr_i, PIF_OFS_REQUEST_3, rd_i) |=> rdata_o == $past(request[2]);
    endproperty
    a_read_flags: assert property (p_read_flags) // [R6]
        else $error("Read of request set three returned the wrong value");

    property p_enable_blocks;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ((request[0] & enable_r[0]) == 8'h00 && (request[1] & enable_r[1]) == 8'h00
         && (request[2] & enable_r[2]) == 8'h00) |=> !periph_irq_o;
    endproperty
    a_enable_blocks: assert property (p_enable_blocks) // [R7]
        else $error("Request passed with no enabled flag pending");

    property p_set3_layout;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (hit(addr_i, PIF_OFS_REQUEST_3, wr_i) && wdata_i == 8'hFF) |=> request[2] == 8'h37;
    endproperty
    a_set3_layout: assert property (p_set3_layout) // [R9]
        else $error("Request set three layout wrong");

    property p_serial_ro;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (hit(addr_i, PIF_OFS_REQUEST_1, wr_i) && serial_rx_pending_i && !serial_tx_pending_i)
        |=> request[0][PIF_BIT_SERIAL_RX] && !request[0][PIF_BIT_SERIAL_TX];
    endproperty
    a_serial_ro: assert property (p_serial_ro) // [R11]
        else $error("Serial flag followed a software write");

    property p_set2_gap;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        hit(addr_i, PIF_OFS_REQUEST_2, wr_i) |=> !request[1][4];
    endproperty
    a_set2_gap: assert property (p_set2_gap) // [R12]
        else $error("Unused bit of request set two is set");

    property p_combined;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ctrl_r[PIF_BIT_PERIPH_GATE] && (request[2] & enable_r[2]) != 8'h00) |=> periph_irq_o;
    endproperty
    a_combined: assert property (p_combined) // [R13]
        else $error("Enabled pending flag did not raise the peripheral request");

    property p_sw_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (hit(addr_i, PIF_OFS_REQUEST_2, wr_i) && wdata_i == 8'h00 && req2_evt_i == 8'h00)
        |=> request[1] == 8'h00;
    endproperty
    a_sw_clear: assert property (p_sw_clear) // [R14]
        else $error("Software write did not clear request set two");

endmodule

// File: pif_src_model.sv
// Source model: peripheral event pulses and serial levels feeding the flags block
`timescale 1ns/1ps

module pif_src_model
    import pif_pkg::*;
(
    input  wire logic clk_sys_i,
    output pif_byte_t req1_evt_o,
    output pif_byte_t req2_evt_o,
    output pif_byte_t req3_evt_o,
    output logic      serial_rx_o,
    output logic      serial_tx_o
);
    // ========================================================================
    // Sources stay quiet until the bench commands them
    // ========================================================================
    initial
    begin
        req1_evt_o  = 8'h00;
        req2_evt_o  = 8'h00;
        req3_evt_o  = 8'h00;
        serial_rx_o = 1'b0;
        serial_tx_o = 1'b0;
    end

    // One-cycle pulse on one request set; real sources never stretch an event
    task automatic pulse(input int s, input pif_byte_t b);
        @(posedge clk_sys_i);
        req1_evt_o <= (s == 1) ? b : 8'h00;
        req2_evt_o <= (s == 2) ? b : 8'h00;
        req3_evt_o <= (s == 3) ? b : 8'h00;
        @(posedge clk_sys_i);
        req1_evt_o <= 8'h00;
        req2_evt_o <= 8'h00;
        req3_evt_o <= 8'h00;
    endtask

    // Serial unit levels: only the unit itself may drop them
    task automatic levels(input logic rx, input logic tx);
        @(posedge clk_sys_i);
        serial_rx_o <= rx;
        serial_tx_o <= tx;
    endtask
endmodule

// File: tb.sv
// Self-checking bench for the peripheral interrupt flags block
`timescale 1ns/1ps

module tb
    import pif_pkg::*;
;
    logic      clk_sys_i;
    logic      nrst_i;
    pif_addr_t addr_i;
    pif_byte_t wdata_i;
    logic      wr_i;
    logic      rd_i;
    pif_byte_t rdata_o;
    pif_byte_t evt1;
    pif_byte_t evt2;
    pif_byte_t evt3;
    logic      rx;
    logic      tx;
    logic      periph_irq_o;
    logic      gate_g;
    logic      gate_p;
    logic      irq_o;
    int        n_fail;
    int        tests_run;
    int        cycles;
    pif_byte_t b;
    // Writable bits per offset 0..6, written independently of the design
    pif_byte_t wm[7] = '{8'hC0, 8'hFF, 8'hEF, 8'h37, 8'hCF, 8'hEF, 8'h37};

    // ========================================================================
    // Clock, instances, hang guard
    // ========================================================================
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    pif_top i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req1_evt_i(evt1), .req2_evt_i(evt2),
        .req3_evt_i(evt3), .serial_rx_pending_i(rx), .serial_tx_pending_i(tx),
        .periph_irq_o(periph_irq_o), .global_irq_gate_o(gate_g),
        .peripheral_irq_gate_o(gate_p), .irq_o(irq_o));

    pif_src_model i_src (.clk_sys_i(clk_sys_i), .req1_evt_o(evt1), .req2_evt_o(evt2),
        .req3_evt_o(evt3), .serial_rx_o(rx), .serial_tx_o(tx));

    // Whole run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    // ========================================================================
    // Tasks and expectation helpers
    // ========================================================================
    function automatic pif_byte_t exp_read(input int a, input pif_byte_t d);
        return d & wm[a];
    endfunction

    task automatic check(input string what, input pif_byte_t exp, input pif_byte_t got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input int a, input pif_byte_t d);
        @(posedge clk_sys_i);
        wr_i    <= 1'b1;
        addr_i  <= pif_addr_t'(a);
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample there
    task automatic rd_chk(input int a, input pif_byte_t exp, input string what);
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= pif_addr_t'(a);
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        check(what, exp, rdata_o);
    endtask

    // Registered outputs need two edges after their cause
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        nrst_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        void'($urandom(96542));
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 11; a++) rd_chk(a, 8'h00, "reset value");
        // Full, empty and random patterns through every enable and request set
        for (int n = 0; n < 48; n++)
        begin
            b = (n < 6) ? 8'hFF : (n < 12) ? 8'h00 : pif_byte_t'($urandom);
            wr_reg(1 + n % 6, b);
            rd_chk(1 + n % 6, exp_read(1 + n % 6, b), "readback");
        end
        for (int a = 1; a < 8; a++) wr_reg(a, (a == 7) ? 8'hFF : 8'h00);
        // Each set: flag without enables, then peripheral gate and enable gating
        for (int s = 1; s < 4; s++)
        begin
            b = pif_byte_t'($urandom) | 8'h01;
            i_src.pulse(s, b);
            settle();
            rd_chk(3 + s, exp_read(3 + s, b), "event flags");
            check("combined no enable", 8'h00, periph_irq_o);
            wr_reg(0, 8'hC0);
            settle();
            check("gates", 8'h03, {gate_g, gate_p});
            check("combined enable off", 8'h00, periph_irq_o);
            wr_reg(s, 8'h01);
            settle();
            check("combined on", 8'h01, periph_irq_o);
            rd_chk(7, 8'h05, "event status");
            rd_chk(9, 8'h03, "summary");
            wr_reg(0, 8'h80);
            settle();
            check("combined gate off", 8'h00, periph_irq_o);
            wr_reg(s, ~b);
            wr_reg(0, 8'hC0);
            settle();
            check("combined other bits", 8'h00, periph_irq_o);
            wr_reg(3 + s, 8'h00);
            rd_chk(3 + s, 8'h00, "flags cleared");
            wr_reg(s, 8'h00);
            wr_reg(0, 8'h00);
            wr_reg(7, 8'hFF);
        end
        // Serial levels: software cannot clear them, the refusal raises the event line
        wr_reg(7, 8'hFF);
        wr_reg(8, 8'h02);
        i_src.levels(1'b1, 1'b0);
        settle();
        rd_chk(4, 8'h20, "receive level");
        wr_reg(4, 8'h00);
        settle();
        rd_chk(4, 8'h20, "receive kept");
        check("event irq", 8'h01, irq_o);
        wr_reg(8, 8'h00);
        settle();
        check("event irq masked", 8'h00, irq_o);
        wr_reg(8, 8'h02);
        wr_reg(7, 8'h02);
        settle();
        check("event irq cleared", 8'h00, irq_o);
        i_src.levels(1'b0, 1'b1);
        settle();
        rd_chk(4, 8'h10, "source cleared");
        // Reset in mid-run with control, enable set one and request set three loaded
        i_src.levels(1'b0, 1'b0);
        wr_reg(1, 8'hA5);
        wr_reg(0, 8'hC0);
        i_src.pulse(3, 8'h37);
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 10; a++) rd_chk(a, 8'h00, "value after reset");
        check("combined after reset", 8'h00, periph_irq_o);
        test_done();
    end
endmodule
